// ### hw/tmr_pkg.sv
/*
 * Constants for the timer block: SFR addresses, control field positions, reset values,
 * clock divider counts.
 * Assumes an 8-bit SFR bus, a 25 MHz system clock, and an external clock already divided by 8.
 */
// Function
// R1: set high overflow flag when upper count byte wraps 0xFF to 0x00.
// R2: in 16-bit mode high flag sets when count wraps 0xFFFF to 0x0000.
// R3: set high flag with timer interrupt enabled requests the interrupt.
// R4: flags are never cleared by hardware; software clears them by writing control.
// R5: low overflow flag sets when low byte wraps, in either mode.
// R6: low-byte enable plus timer interrupt enable raises interrupt on low overflow.
// R7: capture enabled: comparator rising edge copies 16-bit count into reload registers.
// R8: capture event requests timer interrupt when interrupts are enabled.
// R9: split bit 0 gives one 16-bit counter, 1 gives two 8-bit counters.
// R10: timer counts only while run control is 1.
// R11: in split mode run control gates only the upper byte; low byte always runs.
// R12: control bit 1 reads zero and ignores writes.
// R13: external select 0 picks system clock /12, 1 picks external clock /8.
// R14: in split mode external select applies to both bytes; fast selects may override.
// R15: external /8 clock is synchronised to the system clock outside suspend.
// R16: two reload registers hold low and high reload bytes, read/write.
// R17: low count register shows low byte of counter or the split low counter.
// R18: each overflow loads reload contents into the corresponding counter bytes.
// R19: per-byte fast-clock selects choose system clock or the external-select clock.
// R20: capture happens only with capture enable 1 and split mode 0.
// R21: in split mode an upper-byte overflow requests the interrupt.
// R22: with run control 0 the counter holds and count writes apply at once.
package tmr_pkg;
    localparam logic [7:0] TMR_ADDR_CONTROL = 8'h91;
    localparam logic [7:0] TMR_ADDR_RELOAD_LOW = 8'h92;
    localparam logic [7:0] TMR_ADDR_RELOAD_HIGH = 8'h93;
    localparam logic [7:0] TMR_ADDR_COUNT_LOW = 8'h94;
    localparam logic [7:0] TMR_ADDR_COUNT_HIGH = 8'h95;

    localparam int TMR_BIT_HIGH_FLAG = 7;
    localparam int TMR_BIT_LOW_FLAG = 6;
    localparam int TMR_BIT_LOW_IRQ_EN = 5;
    localparam int TMR_BIT_CAPTURE_EN = 4;
    localparam int TMR_BIT_SPLIT = 3;
    localparam int TMR_BIT_RUN = 2;
    localparam int TMR_BIT_EXT_SEL = 0;

    localparam logic [7:0] TMR_CONTROL_RESET = 8'h00;
    localparam logic [7:0] TMR_CONTROL_WMASK = 8'hFD;
    localparam logic [7:0] TMR_BYTE_RESET = 8'h00;
    localparam logic [7:0] TMR_BYTE_MAX = 8'hFF;

    localparam int TMR_SYS_DIVIDE = 12;
    localparam logic [3:0] TMR_SYS_DIV_LAST = 4'(TMR_SYS_DIVIDE - 1);
endpackage

// ### hw/tmr_prescale.sv
/*
 * Count-enable sources: a system clock divided by 12 pulse and the synchronised
 * external clock (already divided by 8) turned into one-cycle edge pulses.
 * Assumes the external clock is slow compared with the system clock.
 */
`timescale 1ns/1ps
module tmr_prescale
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ext_clk_div8,
    output logic sys_div12_tick,
    output logic ext_tick
);
    logic [3:0] div_reg, div_next;
    logic sync1_reg, sync1_next;
    logic sync2_reg, sync2_next;
    logic sync3_reg, sync3_next;

    // ==========================================================
    // divider and synchroniser
    always_comb begin
        div_next = (div_reg == TMR_SYS_DIV_LAST) ? 4'h0 : div_reg + 4'h1;
        sync1_next = ext_clk_div8; // R15
        sync2_next = sync1_reg;
        sync3_next = sync2_reg;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            div_reg <= 4'h0;
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            div_reg <= div_next;
            sync1_reg <= sync1_next;
            sync2_reg <= sync2_next;
            sync3_reg <= sync3_next;
        end
    end

    assign sys_div12_tick = (div_reg == TMR_SYS_DIV_LAST); // R13
    // edge detect only on synchronised stages
    assign ext_tick = sync2_reg & ~sync3_reg;
endmodule

// ### hw/tmr_edge.sv
/*
 * Rising edge detector for the comparator output.
 * Assumes the comparator output is already synchronous to the system clock.
 */
`timescale 1ns/1ps
module tmr_edge
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic level_in,
    output logic rise_pulse
);
    logic prev_reg, prev_next;

    always_comb begin
        prev_next = level_in;
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= prev_next;
        end
    end

    assign rise_pulse = level_in & ~prev_reg;
endmodule

// ### hw/tmr_timer3.sv
/*
 * Timer 3: control, reload and count registers on the SFR bus, 16-bit or split
 * 8-bit auto-reload counting, comparator capture, overflow flags, interrupt request.
 * Assumes the core gives single-cycle SFR read/write strobes with an address, and that
 * the clock-control fast-select bits and timer interrupt enable come in as inputs.
 */
`timescale 1ns/1ps
module tmr_timer3
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire logic high_byte_fast_clock_select,
    input wire logic low_byte_fast_clock_select,
    input wire logic timer_irq_enable,
    input wire logic ext_clk_div8,
    input wire logic analog_comparator_output,
    output logic timer_irq
);
    // ==========================================================
    // decode
    function automatic logic is_addr(input logic [7:0] a, input logic [7:0] target);
        is_addr = (a == target);
    endfunction

    logic wr_ctl, wr_rll, wr_rlh, wr_cl, wr_ch;
    assign wr_ctl = sfr_wr & is_addr(sfr_addr, TMR_ADDR_CONTROL);
    assign wr_rll = sfr_wr & is_addr(sfr_addr, TMR_ADDR_RELOAD_LOW);
    assign wr_rlh = sfr_wr & is_addr(sfr_addr, TMR_ADDR_RELOAD_HIGH);
    assign wr_cl = sfr_wr & is_addr(sfr_addr, TMR_ADDR_COUNT_LOW);
    assign wr_ch = sfr_wr & is_addr(sfr_addr, TMR_ADDR_COUNT_HIGH);

    // ==========================================================
    // state
    logic [7:0] timer_control_reg, timer_control_next;
    logic [7:0] reload_low_byte_reg, reload_low_byte_next;
    logic [7:0] reload_high_byte_reg, reload_high_byte_next;
    logic [7:0] count_low_byte_reg, count_low_byte_next;
    logic [7:0] count_high_byte_reg, count_high_byte_next;
    logic [7:0] rdata_reg, rdata_next;

    logic sys_div12_tick, ext_tick, cmp_rise;

    tmr_prescale u_prescale (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .ext_clk_div8(ext_clk_div8),
        .sys_div12_tick(sys_div12_tick),
        .ext_tick(ext_tick)
    );

    tmr_edge u_cmp_edge (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .level_in(analog_comparator_output),
        .rise_pulse(cmp_rise)
    );

    logic high_flag, low_flag, low_irq_en, capture_en, split, run, ext_sel;
    assign high_flag = timer_control_reg[TMR_BIT_HIGH_FLAG];
    assign low_flag = timer_control_reg[TMR_BIT_LOW_FLAG];
    assign low_irq_en = timer_control_reg[TMR_BIT_LOW_IRQ_EN];
    assign capture_en = timer_control_reg[TMR_BIT_CAPTURE_EN];
    assign split = timer_control_reg[TMR_BIT_SPLIT];
    assign run = timer_control_reg[TMR_BIT_RUN];
    assign ext_sel = timer_control_reg[TMR_BIT_EXT_SEL];

    // ==========================================================
    // count enables
    logic slow_tick, tick_low, tick_high, inc_low, inc_high;
    logic low_wrap, high_wrap, capture;

    always_comb begin
        slow_tick = ext_sel ? ext_tick : sys_div12_tick; // R13 R14
        tick_low = low_byte_fast_clock_select ? 1'b1 : slow_tick; // R19
        tick_high = high_byte_fast_clock_select ? 1'b1 : slow_tick; // R19
        if (split) begin
            inc_low = tick_low; // R11
            inc_high = run & tick_high; // R11
        end else begin
            // 16-bit mode follows the low-byte clock select
            inc_low = run & tick_low; // R10 R22
            inc_high = inc_low & (count_low_byte_reg == TMR_BYTE_MAX);
        end
        low_wrap = inc_low & (count_low_byte_reg == TMR_BYTE_MAX); // R5
        high_wrap = inc_high & (count_high_byte_reg == TMR_BYTE_MAX); // R1 R2
        capture = capture_en & ~split & cmp_rise; // R7 R20
    end

    // ==========================================================
    // register next state
    always_comb begin
        timer_control_next = timer_control_reg;
        reload_low_byte_next = reload_low_byte_reg;
        reload_high_byte_next = reload_high_byte_reg;
        count_low_byte_next = count_low_byte_reg;
        count_high_byte_next = count_high_byte_reg;

        if (wr_ctl) begin
            timer_control_next = sfr_wdata & TMR_CONTROL_WMASK; // R12 R4
        end
        if (wr_rll) begin
            reload_low_byte_next = sfr_wdata; // R16
        end
        if (wr_rlh) begin
            reload_high_byte_next = sfr_wdata; // R16
        end

        // count bytes
        if (split) begin
            if (low_wrap) begin
                count_low_byte_next = reload_low_byte_reg; // R18 R9
            end else if (inc_low) begin
                count_low_byte_next = count_low_byte_reg + 8'h01;
            end
            if (high_wrap) begin
                count_high_byte_next = reload_high_byte_reg; // R18 R9
            end else if (inc_high) begin
                count_high_byte_next = count_high_byte_reg + 8'h01;
            end
        end else begin
            if (high_wrap) begin
                count_low_byte_next = reload_low_byte_reg; // R18 R9
                count_high_byte_next = reload_high_byte_reg; // R18
            end else if (inc_low) begin
                {count_high_byte_next, count_low_byte_next} =
                    {count_high_byte_reg, count_low_byte_reg} + 16'h0001;
            end
        end
        // software write to count wins over counting
        if (wr_cl) begin
            count_low_byte_next = sfr_wdata; // R22
        end
        if (wr_ch) begin
            count_high_byte_next = sfr_wdata; // R22
        end

        // capture wins over a software reload write in the same cycle
        if (capture) begin
            reload_low_byte_next = count_low_byte_reg; // R7
            reload_high_byte_next = count_high_byte_reg; // R7
        end

        // set wins over a software clear in the same cycle
        if (high_wrap | capture) begin
            timer_control_next[TMR_BIT_HIGH_FLAG] = 1'b1; // R1 R2 R8 R21
        end
        if (low_wrap) begin
            timer_control_next[TMR_BIT_LOW_FLAG] = 1'b1; // R5
        end

        // read data
        rdata_next = 8'h00;
        if (sfr_rd) begin
            if (is_addr(sfr_addr, TMR_ADDR_CONTROL)) begin
                rdata_next = timer_control_reg; // R12
            end else if (is_addr(sfr_addr, TMR_ADDR_RELOAD_LOW)) begin
                rdata_next = reload_low_byte_reg;
            end else if (is_addr(sfr_addr, TMR_ADDR_RELOAD_HIGH)) begin
                rdata_next = reload_high_byte_reg;
            end else if (is_addr(sfr_addr, TMR_ADDR_COUNT_LOW)) begin
                rdata_next = count_low_byte_reg; // R17
            end else if (is_addr(sfr_addr, TMR_ADDR_COUNT_HIGH)) begin
                rdata_next = count_high_byte_reg;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rstn) begin
            timer_control_reg <= TMR_CONTROL_RESET;
            reload_low_byte_reg <= TMR_BYTE_RESET;
            reload_high_byte_reg <= TMR_BYTE_RESET;
            count_low_byte_reg <= TMR_BYTE_RESET;
            count_high_byte_reg <= TMR_BYTE_RESET;
            rdata_reg <= 8'h00;
        end else begin
            timer_control_reg <= timer_control_next;
            reload_low_byte_reg <= reload_low_byte_next;
            reload_high_byte_reg <= reload_high_byte_next;
            count_low_byte_reg <= count_low_byte_next;
            count_high_byte_reg <= count_high_byte_next;
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // outputs
    assign sfr_rdata = rdata_reg;
    assign sfr_hit = (sfr_addr >= TMR_ADDR_CONTROL) && (sfr_addr <= TMR_ADDR_COUNT_HIGH);
    // level request; held until software clears the flag
    assign timer_irq = timer_irq_enable & (high_flag | (low_irq_en & low_flag)); // R3 R6 R8 R21
endmodule

// ### bench/tmr_timer3_asserts.sv
/* port-level checks of tmr_timer3.
   assumes single-cycle sfr strobes; bound in below. */
`timescale 1ns/1ps
module tmr_timer3_asserts
    import tmr_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    input wire logic [7:0] sfr_rdata,
    input wire logic sfr_hit,
    input wire logic high_byte_fast_clock_select,
    input wire logic low_byte_fast_clock_select,
    input wire logic timer_irq_enable,
    input wire logic ext_clk_div8,
    input wire logic analog_comparator_output,
    input wire logic timer_irq
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // ==========================================
    // shadow of software-only control bits
    logic [7:0] ctl_reg;
    logic [7:0] ctl_next;
    always_comb begin
        ctl_next = ctl_reg;
        if (sfr_wr && sfr_addr == TMR_ADDR_CONTROL) begin
            ctl_next = sfr_wdata & 8'h3D;
        end
    end
    always_ff @(posedge sys_clk) begin
        ctl_reg <= rstn ? ctl_next : 8'h00;
    end
    property p_idle; !sfr_rd |=> sfr_rdata == 8'h00; endproperty
    property p_unmapped; sfr_rd && !sfr_hit |=> sfr_rdata == 8'h00; endproperty
    property p_hit; sfr_hit == (sfr_addr >= 8'h91 && sfr_addr <= 8'h95); endproperty
    property p_ctl_rd;
        sfr_rd && sfr_addr == TMR_ADDR_CONTROL |=> sfr_rdata[5:0] == $past(ctl_reg[5:0]);
    endproperty
    property p_irq_off; !timer_irq_enable |-> !timer_irq; endproperty
    property p_irq_hold; timer_irq && !sfr_wr |=> timer_irq || !timer_irq_enable; endproperty
    // two cycles of margin: a wrap just before stopping still lands late
    property p_hold;
        ctl_reg[4:2] == 3'b000 && $past(ctl_reg[4:2], 2) == 3'b000 && timer_irq_enable
            && !timer_irq && !sfr_wr |=> !timer_irq;
    endproperty
    property p_capture;
        $rose(analog_comparator_output) && ctl_reg[4] && !ctl_reg[3] && timer_irq_enable
            |-> ##[1:3] timer_irq;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_hit: assert property (p_hit) else $error("address decode wrong");
    a_ctl_rd: assert property (p_ctl_rd) else $error("control readback wrong");
    a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped by itself");
    a_hold: assert property (p_hold) else $error("irq while stopped");
    a_capture: assert property (p_capture) else $error("capture gave no irq");
    c_capture: cover property ($rose(analog_comparator_output) && ctl_reg[4] && !ctl_reg[3]
        ##1 timer_irq);
    c_irq: cover property ($rose(timer_irq));
    c_unmapped: cover property (sfr_rd && !sfr_hit);
endmodule
bind tmr_timer3 tmr_timer3_asserts chk (.sys_clk, .rstn, .sfr_addr, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .sfr_hit, .high_byte_fast_clock_select,
    .low_byte_fast_clock_select, .timer_irq_enable, .ext_clk_div8,
    .analog_comparator_output, .timer_irq);

// ### bench/tmr_cpu_model.sv
/* cpu-side sfr bus master with single-cycle strobes.
   assumes tasks are called only after reset release. */
`timescale 1ns/1ps
module tmr_cpu_model (
    input wire logic sys_clk,
    input wire logic [7:0] sfr_rdata,
    output logic [7:0] sfr_addr,
    output logic sfr_wr,
    output logic sfr_rd,
    output logic [7:0] sfr_wdata
);
    // ==========================================
    // bus cycles, launched at falling edges
    initial begin
        sfr_addr = 8'h00;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_wdata = 8'h00;
    end
    // flags are cleared only through this write path
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_wdata = d;
        sfr_wr = 1'b1;
        @(negedge sys_clk);
        sfr_wr = 1'b0;
        sfr_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        sfr_addr = a;
        sfr_rd = 1'b1;
        @(negedge sys_clk);
        d = sfr_rdata;
        sfr_rd = 1'b0;
    endtask
endmodule

// ### bench/timer3_control_reload_regs_test.sv
/* self-checking bench for tmr_timer3 through its sfr port.
   assumes tmr_cpu_model as bus master and the bound checker. */
`timescale 1ns/1ps
module timer3_control_reload_regs_test;
    import tmr_pkg::*;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic hf = 1'b0;
    logic lf = 1'b0;
    logic ien = 1'b0;
    logic ext = 1'b0;
    logic cmp = 1'b0;
    logic [7:0] addr, wdata, rdata, v, t;
    logic wr, rd, hit, irq;
    int failures = 0;
    int tests_run = 0;
    // ==========================================
    // harness
    always #20 sys_clk = ~sys_clk;
    tmr_cpu_model cpu (.sys_clk, .sfr_rdata(rdata), .sfr_addr(addr), .sfr_wr(wr),
        .sfr_rd(rd), .sfr_wdata(wdata));
    tmr_timer3 uut (.sys_clk, .rstn, .sfr_addr(addr), .sfr_wr(wr), .sfr_rd(rd),
        .sfr_wdata(wdata), .sfr_rdata(rdata), .sfr_hit(hit),
        .high_byte_fast_clock_select(hf), .low_byte_fast_clock_select(lf),
        .timer_irq_enable(ien), .ext_clk_div8(ext), .analog_comparator_output(cmp),
        .timer_irq(irq));
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
        cpu.rd(a, v);
        chk($sformatf("reg %h", a), v, exp);
    endtask
    task automatic give_verdict;
        if (failures == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic waitn(input int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic ext_pulses(input int n);
        repeat (n) begin
            ext = 1'b1;
            waitn(10);
            ext = 1'b0;
            waitn(10);
        end
    endtask
    initial begin
        waitn(6);
        rstn = 1'b1;
        for (int a = 8'h90; a <= 8'h95; a++) rchk(8'(a), 8'h00);
        cpu.wr(TMR_ADDR_CONTROL, 8'h3F);
        rchk(TMR_ADDR_CONTROL, 8'h3D);
        cpu.wr(TMR_ADDR_CONTROL, 8'h00);
        cpu.wr(8'h92, 8'h34);
        cpu.wr(8'h93, 8'h12);
        rchk(8'h92, 8'h34);
        rchk(8'h93, 8'h12);
        cpu.wr(8'h94, 8'hF0);
        cpu.wr(8'h95, 8'hFF);
        lf = 1'b1;
        ien = 1'b1;
        cpu.wr(TMR_ADDR_CONTROL, 8'h04);
        waitn(20);
        cpu.wr(TMR_ADDR_CONTROL, 8'hC0);
        chk("irq", {7'b0, irq}, 8'h01);
        rchk(TMR_ADDR_CONTROL, 8'hC0);
        rchk(8'h95, 8'h12);
        cpu.rd(8'h94, t);
        waitn(5);
        rchk(8'h94, t);
        cpu.wr(8'h94, 8'h77);
        rchk(8'h94, 8'h77);
        rchk(TMR_ADDR_CONTROL, 8'hC0);
        ien = 1'b0;
        waitn(1);
        chk("irq off", {7'b0, irq}, 8'h00);
        ien = 1'b1;
        cpu.wr(8'h95, 8'h00);
        cpu.wr(8'h94, 8'hF0);
        hf = 1'b1;
        cpu.wr(TMR_ADDR_CONTROL, 8'h28);
        waitn(30);
        rchk(8'h95, 8'h00);
        rchk(TMR_ADDR_CONTROL, 8'h68);
        chk("low irq", {7'b0, irq}, 8'h01);
        cpu.wr(TMR_ADDR_CONTROL, 8'h48);
        chk("low masked", {7'b0, irq}, 8'h00);
        cpu.wr(TMR_ADDR_CONTROL, 8'h0C);
        waitn(300);
        rchk(TMR_ADDR_CONTROL, 8'hCC);
        chk("high irq", {7'b0, irq}, 8'h01);
        hf = 1'b0;
        cpu.wr(TMR_ADDR_CONTROL, 8'h00);
        cpu.wr(8'h94, 8'h00);
        cpu.wr(8'h95, 8'h00);
        cpu.wr(TMR_ADDR_CONTROL, 8'h14);
        waitn(40);
        cmp = 1'b1;
        for (int i = 0; i < 10 && irq !== 1'b1; i++) waitn(1);
        chk("cap irq", {7'b0, irq}, 8'h01);
        cmp = 1'b0;
        rchk(TMR_ADDR_CONTROL, 8'h94);
        rchk(8'h93, 8'h00);
        cpu.rd(8'h92, t);
        chk("cap low", {7'b0, t inside {[8'h28:8'h30]}}, 8'h01);
        cpu.wr(TMR_ADDR_CONTROL, 8'h18);
        cmp = 1'b1;
        waitn(5);
        rchk(8'h92, t);
        cmp = 1'b0;
        lf = 1'b0;
        cpu.wr(TMR_ADDR_CONTROL, 8'h00);
        cpu.wr(8'h94, 8'h00);
        cpu.wr(TMR_ADDR_CONTROL, 8'h05);
        ext_pulses(10);
        cpu.wr(TMR_ADDR_CONTROL, 8'h01);
        rchk(8'h94, 8'h0A);
        // split with run off: only the low byte follows the external clock
        cpu.wr(TMR_ADDR_CONTROL, 8'h09);
        ext_pulses(3);
        rchk(8'h94, 8'h0D);
        rchk(8'h95, 8'h00);
        cpu.wr(8'h94, 8'h00);
        cpu.wr(TMR_ADDR_CONTROL, 8'h04);
        waitn(118);
        cpu.wr(TMR_ADDR_CONTROL, 8'h00);
        cpu.rd(8'h94, t);
        chk("div12", {7'b0, t inside {[8'h09:8'h0B]}}, 8'h01);
        give_verdict();
    end
endmodule
